// ---- adcc_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: Byte-wide special function registers on an 8-bit address.
// Notes:   Definitions only.
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

`define ADCC_CTL2_ADDR      8'hD8
`define ADCC_RESLO_ADDR     8'hD9
`define ADCC_RESHI_ADDR     8'hDA
`define ADCC_CTL1_ADDR      8'hEF
`define ADCC_CTL1_RESET     8'h00
`define ADCC_CTL2_RESET     8'h00

`define ADCC_C1_PWR         7
`define ADCC_C1_EXTREF      6
`define ADCC_C1_DIV_HI      5
`define ADCC_C1_DIV_LO      4
`define ADCC_C1_AQ_HI       3
`define ADCC_C1_AQ_LO       2
`define ADCC_C1_TMR         1
`define ADCC_C1_PIN         0

`define ADCC_C2_DONE        7
`define ADCC_C2_DMA         6
`define ADCC_C2_CONT        5
`define ADCC_C2_SINGLE      4
`define ADCC_C2_CS_HI       3
`define ADCC_C2_CS_LO       0

`define ADCC_CONV_CLKS      5'h11
`define ADCC_TEMP_CHANNEL   4'h8

`endif

// ---- adcc_pkg.sv ----
// Purpose: Types shared by the converter control modules.
// Assumes: Constants live in adcc_map.svh.
// Notes:   None.
package adcc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_ACQ, ST_CONV, ST_PUSH} adcc_state_e;
  typedef logic [15:0] adcc_word_t;
endpackage

// ---- adcc_word_if.sv ----
// Purpose: Valid/ready carrier for tagged result words.
// Assumes: Single clock domain.
// Notes:   Word is channel tag in [15:12] and result in [11:0].
`timescale 1ns/1ps
interface adcc_word_if;
  import adcc_pkg::*;
  logic       valid;
  logic       ready;
  adcc_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- adcc_clkdiv.sv ----
// Purpose: Converter clock enable from the master clock.
// Assumes: Division code from control register 1.
// Notes:   The enable is a one-cycle pulse, never a derived clock.
`timescale 1ns/1ps
module adcc_clkdiv (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [1:0] div_sel_i,
  // Enable
  output logic            tick_o
);
  logic [4:0] cnt_ff;
  logic [4:0] last;

  always_comb begin
    unique case (div_sel_i)
      2'b00: last = 5'h07;
      2'b01: last = 5'h03;
      2'b10: last = 5'h0F;
      2'b11: last = 5'h1F;
    endcase
  end

  // Counter restarts when idle so every conversion sees whole converter clocks.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 5'h00;
    end else if (!run_i || cnt_ff >= last) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  assign tick_o = run_i && (cnt_ff >= last);
endmodule // adcc_clkdiv

// ---- adcc_buf2.sv ----
// Purpose: Two-entry buffer for result words.
// Assumes: Single clock domain.
// Notes:   Ready is honest: it falls only when both entries hold data.
`timescale 1ns/1ps
module adcc_buf2 (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Streams
  adcc_word_if.snk  in_if,
  adcc_word_if.src  out_if
);
  import adcc_pkg::*;
  adcc_word_t mem_ff [2];
  logic       wr_ptr_ff;
  logic       rd_ptr_ff;
  logic [1:0] count_ff;
  logic       push;
  logic       pop;

  assign in_if.ready  = (count_ff != 2'd2);
  assign out_if.valid = (count_ff != 2'd0);
  assign out_if.data  = mem_ff[rd_ptr_ff];
  assign push = in_if.valid && in_if.ready;
  assign pop  = out_if.valid && out_if.ready;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_ff[0] <= 16'h0000;
      mem_ff[1] <= 16'h0000;
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= in_if.data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'd0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // adcc_buf2

// ---- adcc_top.sv ----
// Purpose: Sequencing and register control of an 8-channel 12-bit converter.
// Assumes: Converter result arrives synchronous to MCLK_I; pin trigger is asynchronous.
// Notes:   External memory addressing is outside; it reports the last word of a block.
`timescale 1ns/1ps
`include "adcc_map.svh"

// How it works
// R1 - Multiplexer picks one of eight channels
// R2 - Result is straight binary, 4096 codes
// R3 - Finished result lands in high/low registers
// R4 - High register top nibble carries channel
// R5 - Control one at EFH, reset 00H
// R6 - Bit 7 powers converter up/down
// R7 - Bit 6 picks external reference
// R8 - Divide master clock 8,4,16,32
// R9 - Software keeps converter clock under 4.5MHz
// R10 - Conversion lasts 17 converter clocks
// R11 - Acquisition lasts 1 to 4 clocks
// R12 - Software should choose three acquisition clocks
// R13 - Timer overflow starts conversion when enabled
// R14 - Low pulse on pin starts conversion
// R15 - Pin pulses wider than 100 ns
// R16 - Single and continuous modes, any start
// R17 - Capture mode streams samples to memory
// R18 - Power-up loads factory calibration values
// R19 - Temperature input is a ninth channel
// R20 - Control two at D8H, bit addressable
// R21 - Four-bit field selects converted channel
// R22 - Continuous bit restarts after each result
// R23 - Single bit self-clears at cycle end
// R24 - Done flag set by hardware, vector clears
// R25 - Triggers ignored while powered down
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        ARST_N_I,
  // Register port
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic        SFR_WR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  output logic      [7:0]  SFR_RDATA_O,
  input  wire logic        SFR_BIT_WR_I,
  input  wire logic [7:0]  SFR_BIT_ADDR_I,
  input  wire logic        SFR_BIT_VAL_I,
  input  wire logic        INT_ACK_I,
  output logic             CONV_DONE_O,
  // Triggers
  input  wire logic        TIMER2_OVF_I,
  input  wire logic        CONVERT_START_N_I,
  // Analog front end
  output logic             PWR_UP_O,
  output logic             REF_EXT_O,
  output logic [3:0]       MUX_SEL_O,
  output logic             TRACK_O,
  output logic             CONVERT_O,
  output logic             CONV_TICK_O,
  input  wire logic [11:0] ADC_RESULT_I,
  // Calibration
  input  wire logic [15:0] CAL_OFFSET_I,
  input  wire logic [15:0] CAL_GAIN_I,
  output logic [15:0]      CAL_OFFSET_O,
  output logic [15:0]      CAL_GAIN_O,
  output logic             CAL_LOAD_O,
  // Capture stream
  output logic             DMA_VALID_O,
  output logic [15:0]      DMA_DATA_O,
  input  wire logic        DMA_READY_I,
  input  wire logic        DMA_LAST_I
);
  logic [7:0]  ctl1_ff;
  logic [7:0]  ctl2_ff;
  logic [7:0]  nxt_ctl2;
  logic [11:0] result_ff;
  logic [3:0]  tag_ff;
  logic [7:0]  rdata_ff;
  adcc_state_e state_ff;
  logic [4:0]  cnt_ff;
  logic [3:0]  chan_ff;
  logic        dma_run_ff;
  logic [1:0]  pin_sync_ff;
  logic        pin_prev_ff;
  logic        pwr_prev_ff;
  logic [15:0] cal_off_ff;
  logic [15:0] cal_gain_ff;
  logic        cal_load_ff;
  logic        tick;
  logic        pin_fall;
  logic        hw_trig;
  logic        start;
  logic        finish;
  logic        wr_ctl2;
  logic        powered;
  logic [4:0]  acq_last;

  adcc_word_if conv_w ();
  adcc_word_if out_w ();

  // True when a bit write lands on the given bit of control register two.
  function automatic logic bit_hit(input logic [7:0] a, input logic [2:0] idx);
    return (a[7:3] == 5'(`ADCC_CTL2_ADDR >> 3)) && (a[2:0] == idx);
  endfunction

  assign powered  = ctl1_ff[`ADCC_C1_PWR];
  assign wr_ctl2  = SFR_WR_I && (SFR_ADDR_I == `ADCC_CTL2_ADDR);
  assign acq_last = {3'b000, ctl1_ff[`ADCC_C1_AQ_HI:`ADCC_C1_AQ_LO]}; // R11

  adcc_clkdiv u_div (
    .clk_i     (MCLK_I),
    .arst_n_i  (ARST_N_I),
    .run_i     (state_ff == ST_ACQ || state_ff == ST_CONV),
    .div_sel_i (ctl1_ff[`ADCC_C1_DIV_HI:`ADCC_C1_DIV_LO]), // R8
    .tick_o    (tick)
  );

  adcc_buf2 u_buf (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .in_if    (conv_w.snk),
    .out_if   (out_w.src)
  );

  // Pin is asynchronous; the edge detector only looks at the second stage.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_sync_ff <= 2'b11;
      pin_prev_ff <= 1'b1;
    end else begin
      pin_sync_ff <= {pin_sync_ff[0], CONVERT_START_N_I};
      pin_prev_ff <= pin_sync_ff[1];
    end
  end

  assign pin_fall = pin_prev_ff && !pin_sync_ff[1];
  assign hw_trig  = (ctl1_ff[`ADCC_C1_TMR] && TIMER2_OVF_I) // R13
                 || (ctl1_ff[`ADCC_C1_PIN] && pin_fall); // R14

  // Starts are dropped rather than queued, so a trigger that lands mid-conversion is lost.
  assign start = powered && (state_ff == ST_IDLE) // R25
              && (hw_trig || ctl2_ff[`ADCC_C2_SINGLE] || ctl2_ff[`ADCC_C2_CONT] // R16 R22
                  || ctl2_ff[`ADCC_C2_DMA]); // R17

  assign finish = (state_ff == ST_PUSH) && conv_w.ready;

  // Control register one.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl1_ff <= `ADCC_CTL1_RESET; // R5
    end else if (SFR_WR_I && SFR_ADDR_I == `ADCC_CTL1_ADDR) begin
      ctl1_ff <= SFR_WDATA_I;
    end
  end

  // Control register two: byte and bit writes, with hardware set winning over clear.
  always_comb begin
    nxt_ctl2 = ctl2_ff;
    if (wr_ctl2) begin
      nxt_ctl2 = SFR_WDATA_I;
    end
    for (int i = 0; i < 8; i++) begin
      if (SFR_BIT_WR_I && bit_hit(SFR_BIT_ADDR_I, 3'(i))) begin
        nxt_ctl2[i] = SFR_BIT_VAL_I; // R20
      end
    end
    if (INT_ACK_I) begin
      nxt_ctl2[`ADCC_C2_DONE] = 1'b0; // R24
    end
    if (finish && !dma_run_ff && ctl2_ff[`ADCC_C2_SINGLE]) begin
      nxt_ctl2[`ADCC_C2_SINGLE] = 1'b0; // R23
    end
    if (finish && dma_run_ff && DMA_LAST_I) begin
      nxt_ctl2[`ADCC_C2_DMA] = 1'b0;
    end
    if (finish && (!dma_run_ff || DMA_LAST_I)) begin
      nxt_ctl2[`ADCC_C2_DONE] = 1'b1; // R24
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl2_ff <= `ADCC_CTL2_RESET; // R20
    end else begin
      ctl2_ff <= nxt_ctl2;
    end
  end

  // Conversion sequencer.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 5'h00;
      chan_ff    <= 4'h0;
      dma_run_ff <= 1'b0;
    end else if (!powered) begin
      state_ff <= ST_IDLE; // R6
      cnt_ff   <= 5'h00;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cal_load_ff) begin
            state_ff <= ST_CAL;
          end else if (start) begin
            state_ff   <= ST_ACQ;
            cnt_ff     <= 5'h00;
            chan_ff    <= ctl2_ff[`ADCC_C2_CS_HI:`ADCC_C2_CS_LO]; // R21 R19
            dma_run_ff <= ctl2_ff[`ADCC_C2_DMA];
          end
        end
        ST_CAL: begin
          state_ff <= ST_IDLE;
        end
        ST_ACQ: begin
          if (tick) begin
            if (cnt_ff == acq_last) begin
              state_ff <= ST_CONV; // R11
              cnt_ff   <= 5'h00;
            end else begin
              cnt_ff <= cnt_ff + 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (cnt_ff == `ADCC_CONV_CLKS - 5'h01) begin
              state_ff <= ST_PUSH; // R10
            end else begin
              cnt_ff <= cnt_ff + 5'h01;
            end
          end
        end
        ST_PUSH: begin
          if (conv_w.ready) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Result captured as straight binary, tagged with its channel.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      conv_w.data <= 16'h0000;
    end else if (state_ff == ST_CONV && tick && cnt_ff == `ADCC_CONV_CLKS - 5'h01) begin
      conv_w.data <= {chan_ff, ADC_RESULT_I}; // R2 R4
    end
  end

  assign conv_w.valid = (state_ff == ST_PUSH);

  // Capture words go to memory as the sink takes them; others drain at once; every word taken lands in the result registers.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      result_ff <= 12'h000;
      tag_ff    <= 4'h0;
    end else if (out_w.valid && out_w.ready) begin
      result_ff <= out_w.data[11:0]; // R3
      tag_ff    <= out_w.data[15:12]; // R4
    end
  end

  // Steered by the latched mode, so words still buffered when a block ends reach memory.
  assign out_w.ready = dma_run_ff ? DMA_READY_I : 1'b1; // R17
  assign DMA_VALID_O = out_w.valid && dma_run_ff;
  assign DMA_DATA_O  = out_w.data;

  // Factory calibration copied whenever the converter is powered up.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pwr_prev_ff <= 1'b0;
      cal_load_ff <= 1'b0;
      cal_off_ff  <= 16'h0000;
      cal_gain_ff <= 16'h0000;
    end else begin
      pwr_prev_ff <= powered;
      if (powered && !pwr_prev_ff) begin
        cal_load_ff <= 1'b1; // R18
        cal_off_ff  <= CAL_OFFSET_I;
        cal_gain_ff <= CAL_GAIN_I;
      end else if (state_ff == ST_CAL || !powered) begin
        cal_load_ff <= 1'b0;
      end
    end
  end

  // Read data is registered, so it appears one cycle after the address.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (SFR_ADDR_I)
        `ADCC_CTL1_ADDR:  rdata_ff <= ctl1_ff;
        `ADCC_CTL2_ADDR:  rdata_ff <= ctl2_ff;
        `ADCC_RESLO_ADDR: rdata_ff <= result_ff[7:0];
        `ADCC_RESHI_ADDR: rdata_ff <= {tag_ff, result_ff[11:8]};
        default:          rdata_ff <= 8'h00;
      endcase
    end
  end

  assign SFR_RDATA_O  = rdata_ff;
  assign CONV_DONE_O  = ctl2_ff[`ADCC_C2_DONE];
  assign PWR_UP_O     = powered; // R6
  assign REF_EXT_O    = ctl1_ff[`ADCC_C1_EXTREF]; // R7
  assign MUX_SEL_O    = (state_ff == ST_IDLE) ? ctl2_ff[3:0] : chan_ff; // R1 R19
  assign TRACK_O      = (state_ff == ST_ACQ);
  assign CONVERT_O    = (state_ff == ST_CONV);
  assign CONV_TICK_O  = tick;
  assign CAL_OFFSET_O = cal_off_ff;
  assign CAL_GAIN_O   = cal_gain_ff;
  assign CAL_LOAD_O   = (state_ff == ST_CAL);
endmodule // adcc_top

// ---- adcc_afe_model.sv ----
// Purpose: Front end and capture sink model facing the control.
// Assumes: The result is read only while the converter is busy.
// Notes:   Idle result lines wander so a stale sample cannot pass.
`timescale 1ns/1ps
module adcc_afe_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Front end
  input  wire logic        convert_i,
  input  wire logic [3:0]  mux_sel_i,
  output logic      [11:0] result_o,
  // Capture sink
  input  wire logic        stall_i,
  output logic             ready_o
);
  logic [11:0] noise_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) noise_ff <= 12'h5A3;
    else noise_ff <= noise_ff + 12'h3A7;
  end
  // Each input, the temperature one too, gives its own code.
  assign result_o = convert_i ? {mux_sel_i, ~mux_sel_i, mux_sel_i} : noise_ff;
  assign ready_o  = !stall_i;
endmodule // adcc_afe_model

// ---- adcc_top_assertions.sv ----
// Purpose: Port checks of the converter control.
// Assumes: Control one changes only by byte writes.
// Notes:   Tick counts live in small helper counters.
`timescale 1ns/1ps
module adcc_top_chk (
  // Clock and reset
  input wire logic        MCLK_I,
  input wire logic        ARST_N_I,
  // Register port
  input wire logic [7:0]  SFR_ADDR_I,
  input wire logic        SFR_WR_I,
  input wire logic [7:0]  SFR_WDATA_I,
  input wire logic [7:0]  SFR_RDATA_O,
  input wire logic        INT_ACK_I,
  input wire logic        CONV_DONE_O,
  input wire logic        TIMER2_OVF_I,
  // Converter side
  input wire logic        PWR_UP_O,
  input wire logic        TRACK_O,
  input wire logic        CONVERT_O,
  input wire logic        CONV_TICK_O,
  input wire logic        CAL_LOAD_O,
  // Capture stream
  input wire logic        DMA_VALID_O,
  input wire logic [15:0] DMA_DATA_O,
  input wire logic        DMA_READY_I,
  input wire logic        DMA_LAST_I
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic [7:0] c1_ff;
  logic [5:0] gap_ff, conv_ff, acq_ff, div_n;
  assign div_n = c1_ff[5:4] == 2'b01 ? 6'h04 : 6'h08 << (c1_ff[5:4] - c1_ff[5]);
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      c1_ff   <= 8'h00;
      gap_ff  <= 6'h00;
      conv_ff <= 6'h00;
      acq_ff  <= 6'h00;
    end else begin
      if (SFR_WR_I && SFR_ADDR_I == 8'hEF) c1_ff <= SFR_WDATA_I;
      gap_ff  <= CONV_TICK_O ? 6'h01 : gap_ff + {5'h00, gap_ff != 6'h3F};
      conv_ff <= CONVERT_O ? conv_ff + {5'h00, CONV_TICK_O} : 6'h00;
      acq_ff  <= TRACK_O ? acq_ff + {5'h00, CONV_TICK_O} : 6'h00;
    end
  end
  chk_power_bit: assert property (
    SFR_WR_I && SFR_ADDR_I == 8'hEF |=> PWR_UP_O == c1_ff[7])
    else $error("power output wrong");
  chk_cal_pulse: assert property (
    $rose(PWR_UP_O) ##1 !TRACK_O |-> ##1 CAL_LOAD_O ##1 !CAL_LOAD_O)
    else $error("calibration load pulse wrong");
  chk_tick_gap: assert property (
    CONVERT_O && CONV_TICK_O |-> gap_ff == div_n)
    else $error("converter clock ratio wrong");
  chk_conv_len: assert property (
    $fell(CONVERT_O) && PWR_UP_O |-> conv_ff == 6'h11)
    else $error("conversion length wrong");
  chk_acq_len: assert property (
    $fell(TRACK_O) && PWR_UP_O |-> acq_ff == {4'h0, c1_ff[3:2]} + 6'h01)
    else $error("acquisition length wrong");
  chk_off_idle: assert property (
    !PWR_UP_O && !$past(PWR_UP_O) |-> !TRACK_O && !CONVERT_O)
    else $error("activity while powered down");
  chk_timer_start: assert property (
    TIMER2_OVF_I && c1_ff[1] && PWR_UP_O && !TRACK_O && !CONVERT_O |-> ##[1:3] TRACK_O)
    else $error("timer overflow did not start");
  chk_unmapped_read: assert property (
    !(SFR_ADDR_I inside {8'hD8, 8'hD9, 8'hDA, 8'hEF}) |=> SFR_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  chk_ack_clear: assert property (
    INT_ACK_I && CONV_DONE_O && TRACK_O |=> !CONV_DONE_O)
    else $error("done flag not cleared");
  chk_dma_hold: assert property (
    DMA_VALID_O && !DMA_READY_I && !DMA_LAST_I |=> DMA_VALID_O && $stable(DMA_DATA_O))
    else $error("stalled word changed");
  cover property ($fell(CONVERT_O) && PWR_UP_O);
  cover property (DMA_VALID_O && !DMA_READY_I);
  cover property (INT_ACK_I && CONV_DONE_O && TRACK_O);
endmodule // adcc_top_chk

bind adcc_top adcc_top_chk u_chk (.MCLK_I, .ARST_N_I, .SFR_ADDR_I, .SFR_WR_I, .SFR_WDATA_I,
  .SFR_RDATA_O, .INT_ACK_I, .CONV_DONE_O, .TIMER2_OVF_I, .PWR_UP_O, .TRACK_O, .CONVERT_O,
  .CONV_TICK_O, .CAL_LOAD_O, .DMA_VALID_O, .DMA_DATA_O, .DMA_READY_I, .DMA_LAST_I);

// ---- test_adc_conversion_control.sv ----
// Purpose: Self-checking bench of the converter control.
// Assumes: Seeded random stimulus; the model supplies results.
// Notes:   Fast divide codes run once only, as they overrun the clock limit.
`timescale 1ns/1ps
module test_adc_conversion_control;
  logic        mclk, arst_n, wr, bwr, bval, ack, tmr, pin_n, stall, last, pwr, ref_ext;
  logic        trk, cnv, cnv_d, done, dma_v, dma_r;
  logic [3:0]  mux, ch;
  logic [3:0]  chs[4];
  logic [7:0]  addr, wdata, baddr, rdata, v, hi, lo;
  logic [11:0] res;
  logic [15:0] cal_off, cal_gain, coff, cgain, dma_data;
  int          bad_count, check_count, n, k, convs;
  int          divs[4] = '{8, 4, 16, 32};

  adcc_top dut (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(rdata), .SFR_BIT_WR_I(bwr), .SFR_BIT_ADDR_I(baddr), .SFR_BIT_VAL_I(bval),
    .INT_ACK_I(ack), .CONV_DONE_O(done), .TIMER2_OVF_I(tmr), .CONVERT_START_N_I(pin_n),
    .PWR_UP_O(pwr), .REF_EXT_O(ref_ext), .MUX_SEL_O(mux), .TRACK_O(trk), .CONVERT_O(cnv),
    .CONV_TICK_O(), .ADC_RESULT_I(res), .CAL_OFFSET_I(cal_off), .CAL_GAIN_I(cal_gain),
    .CAL_OFFSET_O(coff), .CAL_GAIN_O(cgain), .CAL_LOAD_O(), .DMA_VALID_O(dma_v),
    .DMA_DATA_O(dma_data), .DMA_READY_I(dma_r), .DMA_LAST_I(last));
  adcc_afe_model u_afe (.clk_i(mclk), .arst_n_i(arst_n), .convert_i(cnv), .mux_sel_i(mux),
    .result_o(res), .stall_i(stall), .ready_o(dma_r));

  always #12.5 mclk = ~mclk;

  // Finished conversions, counted from the busy output so every word can be accounted for.
  always @(negedge mclk) begin
    cnv_d <= cnv;
    if (cnv_d === 1'b1 && cnv === 1'b0) convs++;
  end

  function automatic logic [15:0] exp_word(logic [3:0] c);
    return {c, c, ~c, c};
  endfunction

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    @(posedge mclk);
    #1;
    d = rdata;
  endtask

  task automatic bit_wr(logic [2:0] b, logic val);
    @(posedge mclk);
    baddr <= 8'hD8 + b;
    bval  <= val;
    bwr   <= 1'b1;
    @(posedge mclk);
    bwr   <= 1'b0;
  endtask

  // One-cycle pulse: 0 acknowledges the interrupt, 1 is a timer overflow.
  task automatic pulse(int w);
    @(posedge mclk);
    if (w == 0) ack <= 1'b1;
    else tmr <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    tmr <= 1'b0;
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    check("wait_limit", s, 1'b1);
  endtask

  task automatic run_one(logic [1:0] dv, logic [1:0] aq, logic [3:0] c, int how);
    int e;
    e = (aq + 18) * divs[dv];
    wr_reg(8'hEF, {2'b10, dv, aq, how == 1, how == 2});
    wr_reg(8'hD8, {3'b000, how == 0, c});
    if (how == 1) pulse(1);
    if (how == 2) begin
      @(posedge mclk);
      pin_n <= 1'b0;
      // Five cycles keep the low pulse above the minimum width.
      repeat (5) @(posedge mclk);
      pin_n <= 1'b1;
    end
    wait_hi(done, 3000);
    check("conv_time", n >= e - 8 && n <= e + divs[dv] + 8, 1'b1);
    rd_reg(8'hD9, lo);
    rd_reg(8'hDA, hi);
    check("result", {hi, lo}, exp_word(c));
    rd_reg(8'hD8, v);
    check("ctl2_end", v, {4'h8, c});
    pulse(0);
    rd_reg(8'hD8, v);
    check("ctl2_ack", v, {4'h0, c});
  endtask

  task automatic test_done;
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    test_done;
  end

  initial begin
    {mclk, arst_n, wr, bwr, bval, ack, tmr, stall, last} = 9'h000;
    pin_n = 1'b1;
    addr  = 8'h00;
    wdata = 8'h00;
    baddr = 8'h00;
    void'($urandom(32'h3c77));
    cal_off  = 16'($urandom);
    cal_gain = 16'($urandom);
    chs = '{4'h8, 4'h7, 4'h0, 4'($urandom_range(6, 1))};
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    rd_reg(8'hEF, v);
    check("ctl1_reset", v, 8'h00);
    rd_reg(8'hD8, v);
    check("ctl2_reset", v, 8'h00);
    rd_reg(8'hD3, v);
    check("unmapped", v, 8'h00);
    wr_reg(8'hEF, 8'h6B);
    rd_reg(8'hEF, v);
    check("ctl1_rw", {v, pwr, ref_ext}, {8'h6B, 2'b01});
    bit_wr(4, 1'b1);
    pulse(1);
    repeat (400) @(posedge mclk);
    @(negedge mclk);
    check("off_idle", {done, trk, cnv}, 3'b000);
    bit_wr(4, 1'b0);
    // Divide by 16 and three acquisition clocks for normal traffic.
    wr_reg(8'hEF, 8'hA8);
    repeat (3) @(posedge mclk);
    check("cal_off", coff, cal_off);
    check("cal_gain", cgain, cal_gain);
    for (int i = 0; i < 4; i++) run_one(2'(i), 2'(i), chs[i], 0);
    run_one(2'b10, 2'b10, 4'($urandom_range(7, 0)), 1);
    run_one(2'b11, 2'b10, 4'($urandom_range(7, 0)), 2);
    ch = 4'($urandom_range(8, 0));
    wr_reg(8'hD8, {4'h2, ch});
    repeat (3) begin
      wait_hi(done, 3000);
      wait_hi(trk, 100);
      check("restart", trk, 1'b1);
      pulse(0);
    end
    bit_wr(5, 1'b0);
    wait_hi(done, 3000);
    pulse(0);
    repeat (800) @(posedge mclk);
    @(negedge mclk);
    check("cont_stop", {done, trk}, 2'b00);
    rd_reg(8'hDA, hi);
    check("cont_tag", hi[7:4], ch);
    @(posedge mclk);
    convs = 0;
    stall <= 1'b1;
    wr_reg(8'hD8, {4'h4, ch});
    repeat (1500) @(posedge mclk);
    @(negedge mclk);
    check("cap_stall", dma_v, 1'b1);
    k = 0;
    n = 0;
    while ((done !== 1'b1 || dma_v === 1'b1) && n < 6000) begin
      @(posedge mclk);
      stall <= ($urandom_range(2, 0) == 0);
      last  <= (k >= 4);
      @(negedge mclk);
      n++;
      if (dma_v === 1'b1 && dma_r === 1'b1) begin
        check("dma_word", dma_data, exp_word(ch));
        k++;
      end
    end
    @(posedge mclk);
    last  <= 1'b0;
    stall <= 1'b0;
    check("dma_count", k >= 4, 1'b1);
    check("dma_words", 16'(k), 16'(convs));
    rd_reg(8'hD8, v);
    check("cap_end", v, {4'h8, ch});
    test_done;
  end
endmodule // test_adc_conversion_control
